// file: lops_pkg.sv
/*
 * Package for the customer-side line operations block: operations channel
 * frame layout, message codes, node addresses, scrambler taps and reset timing.
 * Assumes a single 10 MHz system clock shared by every user of the package.
 */
package lops_pkg;

    // system clock
    localparam int CLK_HZ = 10000000;

    // operations channel frame: addr[11:9], msg indicator[8], info[7:0]
    localparam int FRAME_W  = 12;
    localparam int ADDR_HI  = 11;
    localparam int ADDR_LO  = 9;
    localparam int DMI_POS  = 8;
    localparam int INFO_HI  = 7;

    localparam logic [2:0] ADDR_OWN   = 3'h0;
    localparam logic [2:0] ADDR_BCAST = 3'h7;

    localparam logic [7:0] MSG_LOOP_ALL = 8'h50;
    localparam logic [7:0] MSG_LOOP_B1  = 8'h51;
    localparam logic [7:0] MSG_LOOP_B2  = 8'h52;
    localparam logic [7:0] MSG_REQ_CRC  = 8'h53;
    localparam logic [7:0] MSG_NOT_CRC  = 8'h54;
    localparam logic [7:0] MSG_NORMAL   = 8'hFF;
    localparam logic [7:0] MSG_HOLD     = 8'h00;
    localparam logic [7:0] MSG_UTC      = 8'hAA;

    // frames needed before acting
    localparam logic [1:0] REPEAT_NEED = 2'h3;

    // scrambler
    localparam int SCR_ORDER  = 23;
    localparam int TAP_TX     = 18;
    localparam int TAP_RX     = 5;
    localparam logic [22:0] SCR_SEED = 23'h000000;

    // receive-reset dwell: least time, as an exact cycle count
    localparam int RX_RESET_MS  = 40;
    localparam int RX_RESET_CYC = (RX_RESET_MS * (CLK_HZ / 1000) + 0);

    typedef enum logic [1:0] {
        LOPS_FULL_RESET,
        LOPS_ACTIVE,
        LOPS_RX_RESET
    } lops_rst_e;

    typedef struct packed {
        logic [2:0] addr;
        logic       dmi;
        logic [7:0] info;
    } lops_frame_s;

    typedef struct packed {
        logic loop_all;
        logic loop_b1;
        logic loop_b2;
        logic crc_corrupt;
        logic crc_notified;
    } lops_act_s;

endpackage

// file: lops_scrambler.sv
/*
 * Self-synchronising scrambler or descrambler, 1 + x^-TAP + x^-23.
 * Assumes the caller asserts hold during frame sync word bits.
 */
`timescale 1ns/100ps

module lops_scrambler #(
    parameter int  TAP     = 18,
    parameter bit  DESCRAM = 1'b0
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // bit stream
    input  wire logic bit_en,
    input  wire logic hold,
    input  wire logic bit_in,
    output logic      bit_out
);

    typedef struct packed {
        logic [22:0] shreg;
        logic        out;
    } lops_scr_s;

    lops_scr_s state_reg;
    lops_scr_s state_next;
    logic      fb;

    always_comb begin
        // (RQ13) tap feedback
        fb         = bit_in ^ state_reg.shreg[TAP-1] ^ state_reg.shreg[lops_pkg::SCR_ORDER-1];
        state_next = state_reg;
        // (RQ17) frozen on sync word
        if (bit_en && !hold) begin
            state_next.out = fb;
            // (RQ16) descrambler shifts received line bits
            state_next.shreg = {state_reg.shreg[21:0], DESCRAM ? bit_in : fb};
        end
    end

    always_ff @(posedge sys_clk) begin
        // (RQ18) seed is never all ones
        if (rst) begin
            state_reg <= '{shreg: lops_pkg::SCR_SEED, out: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign bit_out = state_reg.out;

    // (RQ17) hold keeps state
    a_scr_hold_frozen: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ17)
        (hold || !bit_en) |=> $stable(state_reg.shreg))
        else $error("scrambler advanced during hold");

    // (RQ18) no all-ones state at reset
    a_scr_seed_ok: assert property (@(posedge sys_clk)  // (RQ18)
        $fell(rst) |-> (state_reg.shreg != 23'h7FFFFF))
        else $error("scrambler seeded all ones");

endmodule

// file: lops_core.sv
/*
 * Customer line terminator core: operations channel command interpreter,
 * transmit scrambler, receive descrambler, loopback selection and reset
 * sub-state control. Assumes frames, sync word timing and line bits are
 * delivered synchronous to sys_clk by framing logic outside this block.
 */
`timescale 1ns/100ps

// Functional notes
// (RQ1) accept frame only when address is own code 000 or broadcast 111
// (RQ2) unable-to-comply reply carries own address 000
// (RQ3) addresses 1 to 6 belong to repeaters; treated as foreign
// (RQ4) code 50h loops the whole 2B+D stream back to the network
// (RQ5) codes 51h, 52h loop back bearer one or two alone
// (RQ6) code FFh clears all latched actions and resets the interpreter; code clears only the actions, the repeat count is not reset
// (RQ7) code AAh replies that a valid message is unsupported
// (RQ8) code 53h sends corrupted CRC until return-to-normal
// (RQ9) code 54h notes the network sends corrupted CRC until normal
// (RQ10) hold 00h keeps everything; improper address is answered with hold
// (RQ11) non-standard code blocks must not disturb the protocol
// (RQ12) network-internal code blocks; other undefined codes reserved
// (RQ13) each direction scrambled with 23rd-order polynomial, sync word excluded
// (RQ14) network-to-customer scrambler taps 5 and 23
// (RQ15) customer-to-network scrambler taps 18 and 23
// (RQ16) receiver descrambles with the far-end transmitter polynomial
// (RQ17) scramblers hold state during the sync word
// (RQ18) scrambler register never starts all ones
// (RQ19) user bits enter the scrambler without inversion
// (RQ20) power-up enters full reset, not transmitting
// (RQ21) full reset leaves only on service request, power-up or network tone
// (RQ22) receive reset detects tone, lasts at least 40 ms, then full reset
// (RQ23) frame is 3 address bits, indicator bit, 8 info bits
// (RQ24) act only after three identical consecutive addressed frames
// (RQ25) unrecognised message answered unable-to-comply from third receipt on
// (RQ26) actions latch independently until released
// (RQ27) reserved code blocks are treated as unrecognised
module lops_core #(
    parameter int RX_RESET_CYC = lops_pkg::RX_RESET_CYC
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // operations channel, one frame each strobe
    input  wire logic                 eoc_valid,
    input  wire lops_pkg::lops_frame_s eoc_rx,
    output lops_pkg::lops_frame_s     eoc_tx,
    output lops_pkg::lops_act_s       actions,
    // line bit stream
    input  wire logic                 bit_en,
    input  wire logic                 sync_word,
    input  wire logic                 line_rx_bit,
    output logic                      line_tx_bit,
    output logic                      crc_invert,
    // user side 2B+D bits
    input  wire logic                 user_tx_bit,
    input  wire logic                 user_is_b1,
    input  wire logic                 user_is_b2,
    output logic                      user_rx_bit,
    // start-up control
    input  wire logic                 service_request,
    input  wire logic                 network_wake_tone,
    input  wire logic                 signal_lost,
    output logic                      tx_allowed,
    output logic                      customer_wake_tone,
    output lops_pkg::lops_rst_e       reset_state
);

    typedef struct packed {
        lops_pkg::lops_frame_s last;
        logic [1:0]            count;
        lops_pkg::lops_frame_s tx;
        lops_pkg::lops_act_s   act;
        lops_pkg::lops_rst_e   rs;
        logic [31:0]           timer;
        logic                  fresh;
        logic                  tone;
    } lops_core_s;

    lops_core_s state_reg;
    lops_core_s state_next;
    logic       rx_clear;
    logic       loop_bit;
    logic       scr_in;
    logic       b_sel;

    // supported message codes
    function automatic logic known_msg(input logic [7:0] c);
        known_msg = (c == lops_pkg::MSG_LOOP_ALL) || (c == lops_pkg::MSG_LOOP_B1) ||
                    (c == lops_pkg::MSG_LOOP_B2)  || (c == lops_pkg::MSG_REQ_CRC) ||
                    (c == lops_pkg::MSG_NOT_CRC)  || (c == lops_pkg::MSG_NORMAL) ||
                    (c == lops_pkg::MSG_HOLD);
    endfunction

    function automatic logic addr_ok(input logic [2:0] a);
        addr_ok = (a == lops_pkg::ADDR_OWN) || (a == lops_pkg::ADDR_BCAST);
    endfunction

    always_comb begin
        state_next = state_reg;
        if (eoc_valid) begin
            // (RQ1) address filter; (RQ3) 1..6 are foreign
            if (!addr_ok(eoc_rx.addr)) begin
                // (RQ10) improper address gets hold
                state_next.tx    = '{addr: lops_pkg::ADDR_OWN, dmi: 1'b1, info: lops_pkg::MSG_HOLD};
                state_next.count = 2'h0;
                state_next.last  = eoc_rx;
            end else begin
                // (RQ24) count identical consecutive frames
                if (eoc_rx == state_reg.last && state_reg.count != 2'h0) begin
                    if (state_reg.count != lops_pkg::REPEAT_NEED) begin
                        state_next.count = state_reg.count + 2'h1;
                    end
                end else begin
                    state_next.count = 2'h1;
                end
                state_next.last = eoc_rx;
                state_next.tx   = eoc_rx;
                if (state_next.count == lops_pkg::REPEAT_NEED) begin
                    // (RQ11) (RQ12) (RQ23) (RQ25) (RQ27) data and reserved codes unsupported
                    if (!eoc_rx.dmi || !known_msg(eoc_rx.info)) begin
                        // (RQ7) (RQ2) reply carries own address
                        state_next.tx = '{addr: lops_pkg::ADDR_OWN, dmi: 1'b1, info: lops_pkg::MSG_UTC};
                    end else begin
                        // (RQ26) actions latch independently
                        case (eoc_rx.info)
                            // (RQ4) full loopback
                            lops_pkg::MSG_LOOP_ALL: state_next.act.loop_all = 1'b1;
                            // (RQ5) single bearer loopbacks
                            lops_pkg::MSG_LOOP_B1:  state_next.act.loop_b1 = 1'b1;
                            lops_pkg::MSG_LOOP_B2:  state_next.act.loop_b2 = 1'b1;
                            // (RQ8) corrupt outgoing crc
                            lops_pkg::MSG_REQ_CRC:  state_next.act.crc_corrupt = 1'b1;
                            // (RQ9) network corrupts its crc
                            lops_pkg::MSG_NOT_CRC:  state_next.act.crc_notified = 1'b1;
                            // (RQ6) release everything
                            lops_pkg::MSG_NORMAL:   state_next.act = '0;
                            // (RQ10) hold changes nothing
                            default:                state_next.act = state_reg.act;
                        endcase
                    end
                end
            end
        end

        // reset sub-states
        state_next.tone = 1'b0;
        case (state_reg.rs)
            lops_pkg::LOPS_FULL_RESET: begin
                // (RQ21) only fresh power-up, service request or network tone
                if (network_wake_tone) begin
                    state_next.rs = lops_pkg::LOPS_ACTIVE;
                end else if (state_reg.fresh || service_request) begin
                    state_next.rs   = lops_pkg::LOPS_ACTIVE;
                    state_next.tone = 1'b1;
                end
                state_next.fresh = 1'b0;
            end
            lops_pkg::LOPS_ACTIVE: begin
                if (signal_lost) begin
                    state_next.rs    = lops_pkg::LOPS_RX_RESET;
                    state_next.timer = '0;
                end
            end
            lops_pkg::LOPS_RX_RESET: begin
                // (RQ22) tone detection only, minimum dwell
                if (network_wake_tone) begin
                    state_next.rs = lops_pkg::LOPS_ACTIVE;
                end else if (state_reg.timer >= 32'(RX_RESET_CYC - 1)) begin
                    state_next.rs = lops_pkg::LOPS_FULL_RESET;
                end else begin
                    state_next.timer = state_reg.timer + 32'h1;
                end
            end
            default: state_next.rs = lops_pkg::LOPS_FULL_RESET;
        endcase
        if (state_next.rs != lops_pkg::LOPS_ACTIVE) begin
            // losing the line drops the link, so the interpreter restarts too
            state_next.act   = '0;
            state_next.count = 2'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        // (RQ20) power-up lands in full reset
        if (rst) begin
            state_reg       <= '0;
            state_reg.rs    <= lops_pkg::LOPS_FULL_RESET;
            state_reg.fresh <= 1'b1;
            state_reg.tx    <= '{addr: lops_pkg::ADDR_OWN, dmi: 1'b1, info: lops_pkg::MSG_HOLD};
        end else begin
            state_reg <= state_next;
        end
    end

    // descrambled receive stream feeds user side and loopback
    lops_scrambler #(.TAP(lops_pkg::TAP_RX), .DESCRAM(1'b1)) u_descr (
        // (RQ14) (RQ16) network polynomial
        .sys_clk (sys_clk),
        .rst     (rst),
        .bit_en  (bit_en),
        .hold    (sync_word),
        .bit_in  (line_rx_bit),
        .bit_out (rx_clear)
    );

    assign b_sel = (state_reg.act.loop_b1 && user_is_b1) || (state_reg.act.loop_b2 && user_is_b2);
    // (RQ4) (RQ5) transparent loop selection
    assign loop_bit = (state_reg.act.loop_all || b_sel) ? rx_clear : user_tx_bit;
    // (RQ19) no inversion into scrambler
    assign scr_in = loop_bit;

    lops_scrambler #(.TAP(lops_pkg::TAP_TX), .DESCRAM(1'b0)) u_scr (
        // (RQ15) customer-to-network polynomial
        .sys_clk (sys_clk),
        .rst     (rst),
        .bit_en  (bit_en),
        .hold    (sync_word),
        .bit_in  (scr_in),
        .bit_out (line_tx_bit)
    );

    assign user_rx_bit        = rx_clear;
    assign eoc_tx             = state_reg.tx;
    assign actions            = state_reg.act;
    assign crc_invert         = state_reg.act.crc_corrupt;
    assign reset_state        = state_reg.rs;
    assign tx_allowed         = (state_reg.rs == lops_pkg::LOPS_ACTIVE);
    assign customer_wake_tone = state_reg.tone;

    // (RQ1) foreign address answered hold
    a_foreign_hold: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ1) (RQ10)
        (eoc_valid && !addr_ok(eoc_rx.addr) && !signal_lost) |=>
            (eoc_tx.info == lops_pkg::MSG_HOLD && eoc_tx.addr == lops_pkg::ADDR_OWN))
        else $error("foreign frame not answered with hold");

    // (RQ2) utc reply uses own address
    a_utc_addr: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ2)
        (eoc_tx.info == lops_pkg::MSG_UTC && eoc_tx.dmi) |-> eoc_tx.addr == lops_pkg::ADDR_OWN)
        else $error("unable-to-comply without own address");

    // (RQ24) no full loopback from a single frame
    a_act_needs_three: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ24)
        ($rose(actions.loop_all)) |-> $past(state_reg.count) == 2'h2)
        else $error("loopback latched before third frame");

    // (RQ6) return to normal clears
    a_normal_clears: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ6)
        (eoc_valid && eoc_rx.dmi && eoc_rx.info == lops_pkg::MSG_NORMAL && addr_ok(eoc_rx.addr)
            && state_reg.count == 2'h2 && eoc_rx == state_reg.last) |=> actions == '0)
        else $error("return-to-normal left an action latched");

    // (RQ8) corruption only after third request
    a_crc_follow: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ8)
        $rose(crc_invert) |-> $past(eoc_valid && eoc_rx.dmi && eoc_rx.info == lops_pkg::MSG_REQ_CRC
            && state_reg.count == 2'h2))
        else $error("crc corruption without third request");

    // (RQ20) (RQ21) silent without a cause
    a_fullreset_silent: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ21)
        (reset_state == lops_pkg::LOPS_FULL_RESET && !network_wake_tone && !service_request
            && !state_reg.fresh) |=> (!tx_allowed && !customer_wake_tone))
        else $error("transmitting in full reset");

    // (RQ22) no tone sent from receive reset
    a_rxreset_notone: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ22)
        (reset_state == lops_pkg::LOPS_RX_RESET) |-> !customer_wake_tone && !tx_allowed)
        else $error("activity during receive reset");

    // (RQ21) tone only on request or power-up
    a_tone_cause: assert property (@(posedge sys_clk) disable iff (rst)  // (RQ21)
        $rose(customer_wake_tone) |-> ($past(service_request) || $past(state_reg.fresh)))
        else $error("wake tone without cause");

endmodule

// file: lops_net_model.sv
/*
 * Network side line terminator model: scrambles toward the device with taps
 * 5/23 and descrambles the device stream with taps 18/23.
 * Assumes the bench drives net_bit away from the rising clock edge.
 */
`timescale 1ns/100ps

module lops_net_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // line side
    input  wire logic bit_en,
    input  wire logic sync_word,
    input  wire logic line_tx_bit,
    output logic      line_rx_bit,
    // network side
    input  wire logic net_bit,
    output logic      net_rx_bit
);
    logic [22:0] scr_reg;
    logic [22:0] dsc_reg;

    assign line_rx_bit = net_bit ^ scr_reg[4] ^ scr_reg[22];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scr_reg <= 23'h000001;
            dsc_reg <= 23'h000000;
            net_rx_bit <= 1'b0;
        end else if (bit_en && !sync_word) begin
            scr_reg <= {scr_reg[21:0], line_rx_bit};
            dsc_reg <= {dsc_reg[21:0], line_tx_bit};
            net_rx_bit <= line_tx_bit ^ dsc_reg[17] ^ dsc_reg[22];
        end
    end
endmodule

// file: lops_core_tb.sv
/*
 * Self-checking bench for lops_core with the network side model.
 * Assumes a shortened receive reset dwell; inputs change on falling edges.
 */
`timescale 1ns/100ps

module lops_core_tb;
    localparam int RX_SIM = 20;
    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  eoc_valid = 1'b0;
    lops_pkg::lops_frame_s eoc_rx = '0;
    lops_pkg::lops_frame_s eoc_tx;
    lops_pkg::lops_act_s   actions;
    logic                  bit_en = 1'b0;
    logic                  sync_word = 1'b0;
    logic                  user_tx_bit = 1'b0;
    logic                  user_is_b1 = 1'b0;
    logic                  user_is_b2 = 1'b0;
    logic                  service_request = 1'b0;
    logic                  network_wake_tone = 1'b0;
    logic                  signal_lost = 1'b0;
    logic                  net_bit = 1'b0;
    logic                  line_rx_bit, line_tx_bit, crc_invert, user_rx_bit;
    logic                  tx_allowed, customer_wake_tone, net_rx_bit, rx_seen;
    lops_pkg::lops_rst_e   reset_state;
    int                    n_mismatch = 0;
    int                    comparisons = 0;
    int                    n_wake = 0;

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (customer_wake_tone === 1'b1) n_wake <= n_wake + 1;

    lops_core #(.RX_RESET_CYC(RX_SIM)) u_lops_core (
        .sys_clk(sys_clk), .rst(rst), .eoc_valid(eoc_valid), .eoc_rx(eoc_rx), .eoc_tx(eoc_tx),
        .actions(actions), .bit_en(bit_en), .sync_word(sync_word), .line_rx_bit(line_rx_bit),
        .line_tx_bit(line_tx_bit), .crc_invert(crc_invert), .user_tx_bit(user_tx_bit),
        .user_is_b1(user_is_b1), .user_is_b2(user_is_b2), .user_rx_bit(user_rx_bit),
        .service_request(service_request), .network_wake_tone(network_wake_tone),
        .signal_lost(signal_lost), .tx_allowed(tx_allowed), .customer_wake_tone(customer_wake_tone),
        .reset_state(reset_state));

    lops_net_model u_lops_net_model (
        .sys_clk(sys_clk), .rst(rst), .bit_en(bit_en), .sync_word(sync_word),
        .line_tx_bit(line_tx_bit), .line_rx_bit(line_rx_bit), .net_bit(net_bit), .net_rx_bit(net_rx_bit));

    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic send(input logic [2:0] a, input logic d, input logic [7:0] i);
        @(negedge sys_clk);
        eoc_valid = 1'b1;
        eoc_rx = {a, d, i};
        @(negedge sys_clk);
        eoc_valid = 1'b0;
        tick(2);
    endtask

    // three identical frames: echo each time, action after the third
    task automatic cmd(input logic [2:0] a, input logic [7:0] i, input logic [4:0] p, input logic [4:0] e);
        repeat (2) begin
            send(a, 1'b1, i);
            chk_val(eoc_tx, {a, 1'b1, i});
            chk_val(12'(actions), 12'(p));
        end
        send(a, 1'b1, i);
        chk_val(eoc_tx, {a, 1'b1, i});
        chk_val(12'(actions), 12'(e));
    endtask

    task automatic one_bit(input logic ub, input logic nb, input logic sw);
        @(negedge sys_clk);
        user_tx_bit = ub;
        net_bit = nb;
        sync_word = sw;
        bit_en = 1'b1;
        #10 rx_seen = line_rx_bit;
        @(negedge sys_clk);
        bit_en = 1'b0;
        tick(2);
    endtask

    task automatic wait_state(input lops_pkg::lops_rst_e s, output int n);
        n = 0;
        while (reset_state !== s && n < 100) begin
            tick(1);
            n++;
        end
        if (n >= 100) begin
            n_mismatch++;
            test_done();
        end
    endtask

    task automatic t_reset;
        tick(5);
        chk_val(reset_state, 12'(lops_pkg::LOPS_FULL_RESET));
        chk_val(tx_allowed, 12'h000);
        chk_val(eoc_tx, 12'h100);
        chk_val(actions, 12'h000);
        rst = 1'b0;
        tick(3);
        chk_val(reset_state, 12'(lops_pkg::LOPS_ACTIVE));
        chk_val(n_wake[11:0], 12'h001);
    endtask

    task automatic t_cmds;
        cmd(3'h0, 8'h50, 5'h00, 5'h10);
        cmd(3'h7, 8'h51, 5'h10, 5'h18);
        cmd(3'h7, 8'h52, 5'h18, 5'h1C);
        cmd(3'h0, 8'h53, 5'h1C, 5'h1E);
        chk_val(crc_invert, 12'h001);
        cmd(3'h0, 8'h54, 5'h1E, 5'h1F);
        cmd(3'h0, 8'h00, 5'h1F, 5'h1F);
        for (int a = 1; a < 7; a++) begin
            send(a[2:0], 1'b1, 8'h50);
            chk_val(eoc_tx, 12'h100);
            chk_val(actions, 12'h01F);
        end
        cmd(3'h0, 8'hFF, 5'h1F, 5'h00);
        chk_val(crc_invert, 12'h000);
        // a foreign frame in mid-run restarts the count
        send(3'h0, 1'b1, 8'h50);
        send(3'h0, 1'b1, 8'h50);
        send(3'h3, 1'b1, 8'h50);
        cmd(3'h0, 8'h50, 5'h00, 5'h10);
        cmd(3'h0, 8'hFF, 5'h10, 5'h00);
    endtask

    task automatic t_utc;
        logic [7:0] codes [11] = '{8'h41, 8'h3C, 8'h2F, 8'h1A, 8'h60, 8'h7E, 8'h85, 8'h93, 8'h0F, 8'hC3, 8'hAA};
        for (int k = 0; k < 11; k++) begin
            send(k[0] ? 3'h7 : 3'h0, 1'b1, codes[k]);
            send(k[0] ? 3'h7 : 3'h0, 1'b1, codes[k]);
            chk_val(eoc_tx, {(k[0] ? 3'h7 : 3'h0), 1'b1, codes[k]});
            repeat (2) begin
                send(k[0] ? 3'h7 : 3'h0, 1'b1, codes[k]);
                chk_val(eoc_tx, 12'h1AA);
            end
        end
        repeat (3) send(3'h0, 1'b0, 8'h50);
        chk_val(eoc_tx, 12'h1AA);
        chk_val(actions, 12'h000);
    endtask

    task automatic t_scramble;
        logic [22:0] th;
        logic [22:0] rh;
        logic        ub, ptx, prx;
        int          zeros;
        zeros = 0;
        for (int k = 0; k < 80; k++) begin
            ub = (k < 30) ? 1'b1 : (k[0] ^ k[2] ^ k[3]);
            ptx = line_tx_bit;
            prx = user_rx_bit;
            one_bit(ub, k[1] ^ k[4], (k >= 50 && k < 53));
            if (k >= 50 && k < 53) begin
                chk_val(line_tx_bit, ptx);
                chk_val(user_rx_bit, prx);
            end else begin
                if (k >= 23) begin
                    chk_val(line_tx_bit, ub ^ th[17] ^ th[22]);
                    chk_val(user_rx_bit, rx_seen ^ rh[4] ^ rh[22]);
                    chk_val(user_rx_bit, k[1] ^ k[4]);
                end
                th = {th[21:0], line_tx_bit};
                rh = {rh[21:0], rx_seen};
                if (k < 30 && line_tx_bit === 1'b0) zeros++;
            end
        end
        chk_val(zeros != 0, 12'h001);
    endtask

    task automatic t_loop(input logic [7:0] c, input logic [4:0] e, input logic b1, input logic b2);
        logic s [60];
        logic g [60];
        logic ok, m;
        cmd(3'h0, c, 5'h00, e);
        user_is_b1 = b1;
        user_is_b2 = b2;
        for (int k = 0; k < 60; k++) begin
            s[k] = k[0] ^ k[3] ^ k[4] ^ (k > 20);
            one_bit(1'b0, s[k], 1'b0);
            g[k] = net_rx_bit;
        end
        user_is_b1 = 1'b0;
        user_is_b2 = 1'b0;
        ok = 1'b0;
        for (int l = 0; l < 5; l++) begin
            m = 1'b1;
            for (int i = 30; i < 60; i++) if (g[i] !== s[i - l]) m = 1'b0;
            if (m) ok = 1'b1;
        end
        chk_val(ok, 12'h001);
        cmd(3'h0, 8'hFF, e, 5'h00);
    endtask

    task automatic t_startup;
        int n;
        int w0;
        w0 = n_wake;
        signal_lost = 1'b1;
        tick(2);
        chk_val(reset_state, 12'(lops_pkg::LOPS_RX_RESET));
        chk_val(tx_allowed, 12'h000);
        signal_lost = 1'b0;
        service_request = 1'b1;
        tick(5);
        service_request = 1'b0;
        wait_state(lops_pkg::LOPS_FULL_RESET, n);
        chk_val(n + 7 >= RX_SIM && n + 7 < RX_SIM + 6, 12'h001);
        tick(10);
        chk_val(12'(n_wake - w0), 12'h000);
        network_wake_tone = 1'b1;
        tick(2);
        network_wake_tone = 1'b0;
        chk_val(reset_state, 12'(lops_pkg::LOPS_ACTIVE));
        signal_lost = 1'b1;
        tick(2);
        signal_lost = 1'b0;
        network_wake_tone = 1'b1;
        tick(2);
        network_wake_tone = 1'b0;
        chk_val(reset_state, 12'(lops_pkg::LOPS_ACTIVE));
        signal_lost = 1'b1;
        tick(2);
        signal_lost = 1'b0;
        wait_state(lops_pkg::LOPS_FULL_RESET, n);
        service_request = 1'b1;
        tick(2);
        service_request = 1'b0;
        chk_val(reset_state, 12'(lops_pkg::LOPS_ACTIVE));
        chk_val(12'(n_wake - w0), 12'h001);
    endtask

    initial begin
        #(100 * 50000);
        n_mismatch++;
        test_done();
    end

    initial begin
        t_reset();
        t_cmds();
        t_utc();
        t_scramble();
        t_loop(8'h50, 5'h10, 1'b0, 1'b0);
        t_loop(8'h51, 5'h08, 1'b1, 1'b0);
        t_loop(8'h52, 5'h04, 1'b0, 1'b1);
        t_startup();
        test_done();
    end
endmodule
